// ---- verilog/npl_init_ctrl.sv ----
// power-up initialization, reset timing and page layout control
// =============================================
// Notes on behaviour
// - Spare bytes 800h to 803h hold bad-block data and are never ECC covered.
// - Parity sits in 840h to 87Fh, one 16-byte group per sector.
// - Each codeword is 512 main bytes, 8 meta bytes and 16 parity bytes, fixing up to 8 bits.
// - A factory-bad block holds 00h at byte 2048 of its first or second page.
// - At least 2008 of 2048 blocks stay usable and a bad block disturbs no other block.
// - The device starts initialization alone at the write-inhibit level and loads page 0.
// - Get-feature polling is accepted during initialization, else first access after 1.25 ms.
// - Status bit 0 is the busy flag, high during reset or power-up initialization.
`include "npl_defines.svh"
module npl_init_ctrl
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // supply monitor and chip select pins
   input wire logic write_inhibit_level_in,
   input wire logic chip_sel_n_in,
   // decoded command from the serial front end
   input npl_pkg::npl_cmd_t cmd_in,
   // page byte access from the front end
   input wire logic [11:0] byte_addr_in,
   input wire logic byte_wr_in,
   input wire logic ecc_en_in,
   // array fetch handshake for the first page load
   output logic load_req_out,
   input wire logic load_done_in,
   // block marking lookup, one byte returned per block
   input wire logic [7:0] mark_byte_in,
   // status and layout answers
   output npl_pkg::npl_status_t status_out,
   output logic [7:0] status_reg_out,
   output npl_pkg::npl_byte_info_t byte_info_out,
   output logic wr_allowed_out,
   output logic block_bad_out,
   output logic [11:0] min_valid_blocks_out
);
   import npl_pkg::*;

   // busy span of init and reset; the page load follows it, so both fit the power-on budget
   localparam logic [23:0] INIT_CYC = 24'(`NPL_INIT_CYCLES);

   typedef enum logic [4:0]
   {
      NPL_ST_OFF = 5'b00001,
      NPL_ST_INIT = 5'b00010,
      NPL_ST_LOAD = 5'b00100,
      NPL_ST_READY = 5'b01000,
      NPL_ST_RESET = 5'b10000
   } npl_state_t;

   // =============================================
   // pin synchronisers
   logic [1:0] wi_sync;
   logic [1:0] cs_sync;
   logic [1:0] next_wi_sync;
   logic [1:0] next_cs_sync;

   always_comb
   begin
      next_wi_sync = {wi_sync[0], write_inhibit_level_in};
      next_cs_sync = {cs_sync[0], chip_sel_n_in};
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         wi_sync <= 2'h0;
         cs_sync <= 2'h3;
      end
      else
      begin
         wi_sync <= next_wi_sync;
         cs_sync <= next_cs_sync;
      end
   end

   wire logic supply_ok = wi_sync[1];
   wire logic selected = ~cs_sync[1];

   // =============================================
   // layout decode
   npl_byte_info_t info;

   npl_byte_map u_map
   (
      .addr_in(byte_addr_in),
      .info_out(info)
   );

   // =============================================
   // initialization sequencer
   npl_state_t state;
   npl_state_t next_state;
   logic [23:0] timer;
   logic [23:0] next_timer;
   logic loaded;
   logic next_loaded;
   logic accepted;
   logic next_accepted;
   logic refused;
   logic next_refused;

   wire logic is_reset_cmd = cmd_in.valid && (cmd_in.opcode == `NPL_RESET_OP);
   wire logic is_poll_cmd = cmd_in.valid && (cmd_in.opcode == `NPL_GET_FEAT_OP);

   always_comb
   begin
      next_state = state;
      next_timer = timer;
      next_loaded = loaded;
      next_accepted = 1'b0;
      next_refused = 1'b0;
      case (state)
         NPL_ST_OFF:
         begin
            next_timer = 24'h000000;
            next_loaded = 1'b0;
            if (supply_ok)
            begin
               next_state = NPL_ST_INIT;
            end
         end
         NPL_ST_INIT, NPL_ST_RESET:
         begin
            // polling is served while busy, all else refused
            if (is_poll_cmd)
            begin
               next_accepted = 1'b1;
            end
            else if (cmd_in.valid)
            begin
               next_refused = 1'b1;
            end
            if (timer < INIT_CYC - 24'h000001)
            begin
               next_timer = timer + 24'h000001;
            end
            else
            begin
               next_state = NPL_ST_LOAD;
            end
         end
         NPL_ST_LOAD:
         begin
            if (is_poll_cmd)
            begin
               next_accepted = 1'b1;
            end
            else if (cmd_in.valid)
            begin
               next_refused = 1'b1;
            end
            if (load_done_in)
            begin
               next_loaded = 1'b1;
               next_state = NPL_ST_READY;
            end
         end
         NPL_ST_READY:
         begin
            if (is_reset_cmd)
            begin
               next_timer = 24'h000000;
               next_loaded = 1'b0;
               next_state = NPL_ST_RESET;
            end
            if (cmd_in.valid)
            begin
               next_accepted = 1'b1;
            end
         end
         default:
         begin
            next_state = NPL_ST_OFF;
         end
      endcase
      // supply loss drops straight back to the off state
      if (!supply_ok)
      begin
         next_state = NPL_ST_OFF;
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         state <= NPL_ST_OFF;
         timer <= 24'h000000;
         loaded <= 1'b0;
         accepted <= 1'b0;
         refused <= 1'b0;
      end
      else
      begin
         state <= next_state;
         timer <= next_timer;
         loaded <= next_loaded;
         accepted <= next_accepted;
         refused <= next_refused;
      end
   end

   // =============================================
   // layout and bad-block answers, registered
   npl_byte_info_t info_q;
   logic wr_ok;
   logic bad;
   logic next_wr_ok;
   logic next_bad;

   always_comb
   begin
      // parity bytes are locked while ECC runs; a deselected bus writes nothing
      next_wr_ok = byte_wr_in && selected && (state == NPL_ST_READY)
         && (info.host_writable || !ecc_en_in);
      next_bad = (mark_byte_in != `NPL_ERASED);
   end

   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         info_q <= '0;
         wr_ok <= 1'b0;
         bad <= 1'b0;
      end
      else
      begin
         info_q <= info;
         wr_ok <= next_wr_ok;
         bad <= next_bad;
      end
   end

   // =============================================
   // outputs
   wire logic busy = (state != NPL_ST_READY);

   assign load_req_out = (state == NPL_ST_LOAD);
   assign status_out = '{busy_flag: busy, init_done: (state == NPL_ST_READY),
      cache_loaded: loaded, cmd_accepted: accepted, cmd_refused: refused};
   assign status_reg_out = {7'h00, busy};
   assign byte_info_out = info_q;
   assign wr_allowed_out = wr_ok;
   assign block_bad_out = bad;
   assign min_valid_blocks_out = `NPL_MIN_VALID_BLOCKS;
endmodule

// ---- verilog/npl_defines.svh ----
// constants for the page layout and power-up initialization block
`ifndef NPL_DEFINES_SVH
`define NPL_DEFINES_SVH
`define NPL_MAIN_LAST 12'h7FF
`define NPL_BBM_FIRST 12'h800
`define NPL_BBM_LAST 12'h803
`define NPL_META2_LAST 12'h81F
`define NPL_META1_FIRST 12'h820
`define NPL_META1_LAST 12'h83F
`define NPL_PAR_FIRST 12'h840
`define NPL_PAR_LAST 12'h87F
`define NPL_SECTOR_BYTES 12'h200
`define NPL_PAR_GROUP 12'h010
`define NPL_META1_GROUP 12'h008
`define NPL_BAD_MARK 8'h00
`define NPL_ERASED 8'hFF
`define NPL_RESET_OP 8'hFF
`define NPL_GET_FEAT_OP 8'h0F
`define NPL_ECC_MAX_BITS 4'h8
`define NPL_TOTAL_BLOCKS 12'd2048
`define NPL_MIN_VALID_BLOCKS 12'd2008
`define NPL_CLK_MHZ 250
`define NPL_POR_NS 1250000
`define NPL_WI_WAIT_NS 250000
`define NPL_POR_CYCLES ((`NPL_POR_NS * `NPL_CLK_MHZ) / 1000)
`define NPL_WI_WAIT_CYCLES (((`NPL_WI_WAIT_NS * `NPL_CLK_MHZ) + 999) / 1000)
// own busy span; kept short of the power-on budget so the page load still lands inside it
`define NPL_INIT_NS 250000
`define NPL_INIT_CYCLES ((`NPL_INIT_NS * `NPL_CLK_MHZ) / 1000)
`endif

// ---- verilog/npl_pkg.sv ----
// types for the page layout and power-up initialization block
package npl_pkg;
   typedef enum logic [2:0]
   {
      NPL_REGION_MAIN = 3'h0,
      NPL_REGION_BBM = 3'h1,
      NPL_REGION_META2 = 3'h2,
      NPL_REGION_META1 = 3'h3,
      NPL_REGION_PARITY = 3'h4,
      NPL_REGION_NONE = 3'h5
   } npl_region_t;

   typedef struct packed
   {
      npl_region_t region;
      logic ecc_covered;
      logic host_writable;
      logic [1:0] sector;
      logic [11:0] parity_base;
   } npl_byte_info_t;

   typedef struct packed
   {
      logic valid;
      logic [7:0] opcode;
   } npl_cmd_t;

   typedef struct packed
   {
      logic busy_flag;
      logic init_done;
      logic cache_loaded;
      logic cmd_accepted;
      logic cmd_refused;
   } npl_status_t;
endpackage

// ---- verilog/npl_byte_map.sv ----
// classifies one page byte address into its layout region
`include "npl_defines.svh"
module npl_byte_map
(
   // address to classify
   input wire logic [11:0] addr_in,
   // layout answer
   output npl_pkg::npl_byte_info_t info_out
);
   import npl_pkg::*;

   always_comb
   begin
      info_out = '0;
      info_out.region = NPL_REGION_NONE;
      if (addr_in <= `NPL_MAIN_LAST)
      begin
         info_out.region = NPL_REGION_MAIN;
         info_out.ecc_covered = 1'b1;
         info_out.host_writable = 1'b1;
         info_out.sector = addr_in[10:9];
      end
      else if (addr_in <= `NPL_BBM_LAST)
      begin
         // bad-block bytes stay outside every codeword
         info_out.region = NPL_REGION_BBM;
         info_out.host_writable = 1'b1;
      end
      else if (addr_in <= `NPL_META2_LAST)
      begin
         info_out.region = NPL_REGION_META2;
         info_out.host_writable = 1'b1;
         info_out.sector = addr_in[3:2];
      end
      else if (addr_in <= `NPL_META1_LAST)
      begin
         info_out.region = NPL_REGION_META1;
         info_out.ecc_covered = 1'b1;
         info_out.host_writable = 1'b1;
         info_out.sector = addr_in[4:3];
      end
      else if (addr_in <= `NPL_PAR_LAST)
      begin
         info_out.region = NPL_REGION_PARITY;
         info_out.ecc_covered = 1'b1;
         info_out.host_writable = 1'b0;
         info_out.sector = addr_in[5:4];
      end
      info_out.parity_base = `NPL_PAR_FIRST + {6'h00, info_out.sector, 4'h0};
   end
endmodule

// ---- tb/npl_array_model.sv ----
// array side model: first page fetch and per-block bad marks
module npl_array_model
#(
   parameter int LOAD_DELAY = 20
)
(
   input wire logic core_clk_in,
   input wire logic load_req_in,
   output logic load_done_out,
   input wire logic [10:0] blk_in,
   input wire logic page_in,
   output logic [7:0] mark_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic done = 1'b0;
   // ==========
   // page load answers after a busy span, as a slow array read would
   always @(posedge core_clk_in)
   begin
      cnt <= load_req_in && !done ? cnt + 1 : 0;
      done <= load_req_in && cnt == LOAD_DELAY;
   end
   assign load_done_out = done;
   // one block in seven is bad, marked on only one of its first two pages
   assign mark_out = blk_in % 7 == 3 && page_in == blk_in[0] ? 8'h00 : 8'hFF;
endmodule

// ---- tb/npl_init_asserts.sv ----
// port assertions for the init and layout controller
module npl_init_asserts
   import npl_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input npl_pkg::npl_cmd_t cmd_in,
   input wire logic [11:0] byte_addr_in,
   input wire logic load_req_out,
   input wire logic load_done_in,
   input wire logic [7:0] mark_byte_in,
   input npl_pkg::npl_status_t status_out,
   input npl_pkg::npl_byte_info_t byte_info_out,
   input wire logic block_bad_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);
   // ==========
   // init steps, layout and bad-block checks
   sequence s_ready;
      ##1 !status_out.busy_flag && status_out.cache_loaded;
   endsequence
   sequence s_hold;
      status_out.busy_flag [*8];
   endsequence
   property p_bbm;
      byte_addr_in inside {[12'h800:12'h803]} |=> !byte_info_out.ecc_covered;
   endproperty
   a_bbm: assert property (p_bbm) else $error("bad mark bytes covered");
   property p_par;
      byte_addr_in inside {[12'h840:12'h87F]} |=>
         byte_info_out.parity_base == {$past(byte_addr_in[11:4]), 4'h0};
   endproperty
   a_par: assert property (p_par) else $error("parity group wrong");
   property p_main;
      byte_addr_in < 12'h800 |=> byte_info_out.ecc_covered
         && byte_info_out.sector == $past(byte_addr_in[10:9]);
   endproperty
   a_main: assert property (p_main) else $error("main sector wrong");
   property p_mark;
      1'b1 |=> block_bad_out == ($past(mark_byte_in) != 8'hFF);
   endproperty
   a_mark: assert property (p_mark) else $error("bad block flag wrong");
   property p_load;
      load_req_out && load_done_in |-> s_ready;
   endproperty
   a_load: assert property (p_load) else $error("not ready after load");
   property p_poll;
      load_req_out && cmd_in.valid && cmd_in.opcode == 8'h0F |=> status_out.cmd_accepted;
   endproperty
   a_poll: assert property (p_poll) else $error("poll not accepted");
   property p_refuse;
      load_req_out && cmd_in.valid && cmd_in.opcode != 8'h0F |=> status_out.cmd_refused;
   endproperty
   a_refuse: assert property (p_refuse) else $error("busy command taken");
   property p_rst;
      !status_out.busy_flag && cmd_in.valid && cmd_in.opcode == 8'hFF
         |=> status_out.cmd_accepted ##0 s_hold;
   endproperty
   a_rst: assert property (p_rst) else $error("reset not busy");
endmodule
bind npl_init_ctrl npl_init_asserts u_asserts (.*);

// ---- tb/npl_init_ctrl_tb.sv ----
// bench for the init and layout controller
`include "npl_defines.svh"
module npl_init_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import npl_pkg::*;
   typedef struct packed {npl_byte_info_t i; logic w; logic b;} npl_note_t;
   logic clk = 1'b0, rst = 1'b1, wi = 1'b0, cs_n = 1'b1, wr = 1'b0, ecc = 1'b1;
   logic pg = 1'b0, lv = 1'b0, ld = 1'b0, rdy = 1'b0, lreq, ldone, wok, bad;
   logic [11:0] addr = 12'h000, minv;
   logic [10:0] blk = 11'h000;
   logic [7:0] mark, sreg, op;
   npl_cmd_t cmd = '0;
   npl_status_t st;
   npl_byte_info_t inf;
   npl_note_t ql[$];
   logic [1:0] qc[$];
   int failures = 0, total_checks = 0;
   realtime t0;
   npl_init_ctrl u_dut (.core_clk_in(clk), .sys_rst_in(rst), .write_inhibit_level_in(wi),
      .chip_sel_n_in(cs_n), .cmd_in(cmd), .byte_addr_in(addr), .byte_wr_in(wr),
      .ecc_en_in(ecc), .load_req_out(lreq), .load_done_in(ldone), .mark_byte_in(mark),
      .status_out(st), .status_reg_out(sreg), .byte_info_out(inf), .wr_allowed_out(wok),
      .block_bad_out(bad), .min_valid_blocks_out(minv));
   npl_array_model #(.LOAD_DELAY(20)) u_arr (.core_clk_in(clk), .load_req_in(lreq),
      .load_done_out(ldone), .blk_in(blk), .page_in(pg), .mark_out(mark));
   // ==========
   // tasks
   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic end_sim();
      if (failures == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic send(input logic [7:0] c, input logic [1:0] e);
      cmd = '{1'b1, c};
      qc.push_back(e);
      tick(1);
      cmd = '0;
      tick(1);
   endtask
   task automatic lay(input logic [11:0] a);
      npl_note_t n;
      addr = a;
      {wr, ecc, pg} = 3'($urandom);
      blk = 11'($urandom);
      lv = 1'b1;
      if (a < 12'h800)
         n.i = '{NPL_REGION_MAIN, 1'b1, 1'b1, a[10:9], 12'h000};
      else if (a < 12'h804)
         n.i = '{NPL_REGION_BBM, 1'b0, 1'b1, 2'h0, 12'h000};
      else if (a < 12'h820)
         n.i = '{NPL_REGION_META2, 1'b0, 1'b1, a[3:2], 12'h000};
      else if (a < 12'h840)
         n.i = '{NPL_REGION_META1, 1'b1, 1'b1, a[4:3], 12'h000};
      else
         n.i = '{NPL_REGION_PARITY, 1'b1, 1'b0, a[5:4], 12'h000};
      n.i.parity_base = 12'h840 + {6'h00, n.i.sector, 4'h0};
      n.w = wr && rdy && (n.i.host_writable || !ecc);
      n.b = blk % 7 == 3 && pg == blk[0];
      ql.push_back(n);
      tick(1);
   endtask
   // ==========
   // result watcher
   always @(posedge clk)
      ld <= lv;
   always @(posedge clk)
   begin
      npl_note_t n;
      logic [1:0] c;
      #2;
      if (st.cmd_accepted || st.cmd_refused)
      begin
         c = qc.pop_front();
         chk({st.cmd_accepted, st.cmd_refused} === c, "cmd answer");
      end
      if (ld)
      begin
         n = ql.pop_front();
         chk(inf === n.i && bad === n.b, "layout");
         chk(wok === n.w, "write gate");
      end
   end
   initial
   begin
      forever #2 clk = ~clk;
   end
   // one init span of about 250 us plus the scenarios, with margin
   initial
   begin
      #300000;
      failures++;
      end_sim();
   end
   initial
   begin
      logic [11:0] edg[9] = '{12'h7FF, 12'h800, 12'h803, 12'h804, 12'h81F, 12'h820,
         12'h83F, 12'h840, 12'h87F};
      void'($urandom(49546));
      tick(16);
      rst = 1'b0;
      tick(4);
      wi = 1'b1;
      t0 = $realtime;
      tick(8);
      cs_n = 1'b0;
      chk(st.busy_flag === 1'b1 && sreg === 8'h01 && lreq === 1'b0, "init busy");
      chk(minv === 12'h7D8, "valid blocks");
      foreach (edg[i]) lay(edg[i]);
      repeat (40) lay(12'($urandom_range(12'h87F)));
      lv = 1'b0;
      op = 8'($urandom);
      // no reset opcode this early: the host has not yet waited out the supply settling
      if (op == 8'h0F || op == 8'hFF)
         op = 8'h00;
      send(8'h0F, 2'b10);
      send(op, 2'b01);
      for (int i = 0; i < `NPL_INIT_CYCLES + 100 && lreq !== 1'b1; i++) tick(1);
      chk(lreq === 1'b1 && $realtime - t0 >= `NPL_INIT_NS, "load timing");
      send(8'h0F, 2'b10);
      send(op, 2'b01);
      for (int i = 0; i < 100 && st.busy_flag !== 1'b0; i++) tick(1);
      chk(st.cache_loaded === 1'b1 && st.init_done === 1'b1 && sreg === 8'h00, "ready");
      chk($realtime - t0 <= `NPL_POR_NS, "ready in budget");
      rdy = 1'b1;
      repeat (60) lay(12'($urandom_range(12'h87F)));
      lv = 1'b0;
      rdy = 1'b0;
      send(8'hFF, 2'b10);
      send(8'h0F, 2'b10);
      send(8'hFF, 2'b01);
      tick(8);
      chk(st.busy_flag === 1'b1 && qc.size() == 0 && ql.size() == 0, "reset busy");
      chk(sreg === 8'h01, "reset status");
      end_sim();
   end
endmodule
